// file: src/pswc_ctrl.sv
`timescale 1ns/10ps
// Overview of operation
// [R1] D0 normal, D1/D2 sleep by clock gating
// [R2] Sleep clears ready; only control readable
// [R3] Host only reads control, writes test
// [R4] Writes ignored until one read occurs
// [R5] Test write wakes to D0, resets state
// [R6] Writing 01 enters D1, PHY clocks run
// [R7] D1 detection sets wake status 10b
// [R8] D1 pin needs frame and pin enables
// [R9] Interrupt status set regardless pin enable
// [R10] Host sets energy powerdown before D2
// [R11] D2 gates MAC, bus, internal clock
// [R12] D2 carrier sets status 01b, pin
// [R13] Host clears powerdown after ready
// [R14] Interrupt clears by one when source gone
// [R15] Pulse select: 50 ms or static pin
// [R16] Pin drops on status or enable clear
// [R17] General powerdown; release auto-resets PHY
// [R18] Energy powerdown; energy sets flag INT7.1
// [R19] Wake status stays readable
// [R20] Ready returns within 2 ms of wake
// [R21] D0 encodes 00; no event reads 00
module pswc_ctrl
  import pswc_pkg::*;
#(
  parameter int PULSE_CYC = PSWC_PULSE_CYC  // Wake pin pulse length
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Wake detectors and line
  input  wire logic        frame_det_i,    // Wake frame or remote-wake packet seen
  input  wire logic        line_energy_present_i,
  // Clock gates and PHY controls
  output logic             mac_clk_en_o,   // MAC transmit and general logic
  output logic             mac_rxpm_clk_en_o,
  output logic             bus_clk_en_o,   // Host bus interface
  output logic             int_clk_en_o,   // Internal clock
  output logic             phy_clk_en_o,
  output logic             phy_powered_o,  // PHY analog powered up
  output logic             phy_reset_o,    // Automatic PHY reset
  // Events
  output logic             wake_pin_o,
  output logic             wake_int_o      // Wake interrupt status level
);
  // Complete controller state
  typedef struct packed {
    pswc_state_t pst;
    logic        ready;
    logic        read_seen;
    logic        pin_en;
    logic        psel;
    logic [1:0]  wst;
    logic        wf_en;
    logic        energy_detect_enable;
    logic        wint;
    logic        gpd;
    logic        edpd;
    logic        eon_flag;
    logic        energy_d;
    logic        hit_d;     // Detection seen last cycle, for edge finding
    logic [6:0]  wcnt;
    logic [4:0]  rcnt;
    logic [15:0] rdata;
    logic        mac_en;
    logic        rxpm_en;
    logic        bus_en;
    logic        ic_en;
    logic        phy_en;    // PHY clock enable, registered
    logic        phy_pwr;
    logic        phy_rst;
  } pswc_st_t;

  pswc_st_t   st_reg;
  pswc_st_t   st_next;
  pswc_pin_if pin_if ();

  // Power state field value from internal state
  function automatic logic [1:0] pst_field(input pswc_state_t s);
    case (s)
      PSWC_S_D1: pst_field = PSWC_PST_D1;
      PSWC_S_D2: pst_field = PSWC_PST_D2;
      default:   pst_field = PSWC_PST_D0; // [R21]
    endcase
  endfunction : pst_field

  // Power management control word as software sees it
  function automatic logic [15:0] ctrl_word(input pswc_st_t s);
    logic [15:0] w;
    w = 16'h0;
    w[PSWC_RDY_BIT]                   = s.ready;
    w[PSWC_PINEN_BIT]                 = s.pin_en;
    w[PSWC_PSEL_BIT]                  = s.psel;
    w[PSWC_WST_LSB+1:PSWC_WST_LSB]   = s.wst; // [R19]
    w[PSWC_EDEN_BIT]                  = s.energy_detect_enable;
    w[PSWC_WFEN_BIT]                  = s.wf_en;
    w[PSWC_PST_LSB+1:PSWC_PST_LSB]   = pst_field(s.pst);
    ctrl_word = w;
  endfunction : ctrl_word

  // Source of the wake interrupt and pin: status with its enable
  logic src_active;
  logic frame_hit;
  logic edet_hit;
  logic wr_ok;
  assign src_active = ((st_reg.wst == PSWC_WST_FRAME) && st_reg.wf_en) ||
                      ((st_reg.wst == PSWC_WST_EDET) && st_reg.energy_detect_enable);
  assign frame_hit  = (st_reg.pst == PSWC_S_D1) && frame_det_i && st_reg.wf_en;
  assign edet_hit   = (st_reg.pst == PSWC_S_D2) && line_energy_present_i && st_reg.energy_detect_enable;
  // Writes only count once a read was seen and the device is ready
  assign wr_ok      = wr_i && st_reg.read_seen && st_reg.ready; // [R4]

  // A level detector input or a carrier that stays up would retrigger the pulse every
  // cycle, so only the first cycle of a detection counts as a wake event
  assign pin_if.event_p   = (frame_hit || edet_hit) && !st_reg.hit_d && st_reg.pin_en; // [R8] [R12]
  // The status is registered one cycle late, so a fresh hit keeps the pin source alive
  assign pin_if.active    = (src_active || frame_hit || edet_hit) && st_reg.pin_en;  // [R16]
  assign pin_if.pulse_sel = st_reg.psel;

  // Next-state logic for power state, registers and clock gates
  always_comb begin
    st_next = st_reg;
    st_next.rdata    = 16'h0;
    st_next.energy_d = line_energy_present_i;
    // Reset value matches the idle level, so no false event follows reset
    st_next.hit_d    = frame_hit || edet_hit;
    // Read path: only the control word while not ready
    if (rd_i) begin
      st_next.read_seen = 1'b1; // [R4]
      if (addr_i == PSWC_ADDR_PMCTRL) begin
        st_next.rdata = ctrl_word(st_reg);
      end else if (st_reg.ready) begin // [R2]
        case (addr_i)
          PSWC_ADDR_INTSTS: st_next.rdata = {15'h0, st_reg.wint};
          PSWC_ADDR_PHYCTL: st_next.rdata = {14'h0, st_reg.edpd, st_reg.gpd};
          PSWC_ADDR_PHYINT: begin
            st_next.rdata    = {14'h0, st_reg.eon_flag, 1'b0};
            st_next.eon_flag = 1'b0; // Read clears
          end
          default:          st_next.rdata = 16'h0;
        endcase
      end
    end
    // Wake detection; set wins over any clear this cycle
    if (frame_hit) begin
      st_next.wst = PSWC_WST_FRAME; // [R7]
    end
    if (edet_hit) begin
      st_next.wst = PSWC_WST_EDET;  // [R12]
    end
    // Host writes while awake
    if (wr_ok) begin
      case (addr_i)
        PSWC_ADDR_PMCTRL: begin
          st_next.pin_en = wdata_i[PSWC_PINEN_BIT];
          st_next.psel   = wdata_i[PSWC_PSEL_BIT];
          st_next.wf_en  = wdata_i[PSWC_WFEN_BIT];
          st_next.energy_detect_enable  = wdata_i[PSWC_EDEN_BIT];
          if (!frame_hit && !edet_hit) begin
            st_next.wst = wdata_i[PSWC_WST_LSB+1:PSWC_WST_LSB];
          end
          case (wdata_i[PSWC_PST_LSB+1:PSWC_PST_LSB])
            PSWC_PST_D1: begin
              st_next.pst   = PSWC_S_D1; // [R6]
              st_next.ready = 1'b0;      // [R2]
            end
            PSWC_PST_D2: begin
              st_next.pst   = PSWC_S_D2; // [R10]
              st_next.ready = 1'b0;      // [R2]
            end
            default: st_next.pst = st_reg.pst;
          endcase
        end
        PSWC_ADDR_INTSTS: begin
          if (wdata_i[PSWC_WINT_BIT] && !src_active) begin
            st_next.wint = 1'b0; // [R14]
          end
        end
        PSWC_ADDR_PHYCTL: begin
          st_next.gpd  = wdata_i[PSWC_GPD_BIT];
          st_next.edpd = wdata_i[PSWC_EDPD_BIT];
          if (st_reg.gpd && !wdata_i[PSWC_GPD_BIT]) begin
            st_next.rcnt = 5'(PSWC_PHYRST_CYC); // [R17]
          end
        end
        default: st_next.pst = st_reg.pst;
      endcase
    end
    // Wake-up write to the test register, allowed while asleep
    if (wr_i && (addr_i == PSWC_ADDR_TEST) &&
        ((st_reg.pst == PSWC_S_D1) || (st_reg.pst == PSWC_S_D2))) begin
      st_next.pst       = PSWC_S_WAKE; // [R5]
      st_next.wcnt      = 7'(PSWC_WAKE_DLY);
      st_next.read_seen = 1'b0;        // [R4]
    end
    // Clock restart delay, then ready
    if (st_reg.pst == PSWC_S_WAKE) begin
      if (st_reg.wcnt == 7'h0) begin
        st_next.pst   = PSWC_S_D0;
        st_next.ready = 1'b1; // [R20]
      end else begin
        st_next.wcnt = st_reg.wcnt - 7'h1;
      end
    end
    // Interrupt status set while the source is active; only a host write clears it
    if (src_active) begin
      st_next.wint = 1'b1; // [R9]
    end
    // Energy-on flag on return of line energy in energy powerdown
    if (st_reg.edpd && line_energy_present_i && !st_reg.energy_d) begin
      st_next.eon_flag = 1'b1; // [R18]
    end
    // Automatic PHY reset countdown
    if (st_reg.rcnt != 5'h0) begin
      st_next.rcnt = st_reg.rcnt - 5'h1;
    end
    st_next.phy_rst = (st_next.rcnt != 5'h0);
    // Clock gates per state
    case (st_next.pst)
      // D1 keeps the PHY and the receive power-management logic clocked
      PSWC_S_D1: begin
        st_next.mac_en  = 1'b0;  // [R1] [R6]
        st_next.rxpm_en = 1'b1;
        st_next.bus_en  = 1'b0;
        st_next.ic_en   = 1'b1;
        st_next.phy_en  = 1'b1;
      end
      // D2 stops every clock; only the line energy input stays watched
      PSWC_S_D2: begin
        st_next.mac_en  = 1'b0;  // [R11]
        st_next.rxpm_en = 1'b0;
        st_next.bus_en  = 1'b0;
        st_next.ic_en   = 1'b0;
        st_next.phy_en  = 1'b0;
      end
      // Normal state and the wake delay run every clock
      default: begin
        st_next.mac_en  = 1'b1;
        st_next.rxpm_en = 1'b1;
        st_next.bus_en  = 1'b1;
        st_next.ic_en   = 1'b1;
        st_next.phy_en  = 1'b1;
      end
    endcase
    // PHY analog power: off in general powerdown or idle energy powerdown
    st_next.phy_pwr = !st_next.gpd && !(st_next.edpd && !line_energy_present_i); // [R17] [R18]
  end

  // State register; configuration survives sleep untouched
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg         <= '0;
      st_reg.pst     <= PSWC_S_D0;
      st_reg.ready   <= 1'b1;
      st_reg.mac_en  <= 1'b1;
      st_reg.rxpm_en <= 1'b1;
      st_reg.bus_en  <= 1'b1;
      st_reg.ic_en   <= 1'b1;
      st_reg.phy_en  <= 1'b1;
      st_reg.phy_pwr <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // Wake pin driver
  pswc_pin_drv #(
    .PULSE_CYC (PULSE_CYC)
  ) u_pin (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .p     (pin_if.drv)
  );

  // Outputs, all from flip-flops
  assign rdata_o           = st_reg.rdata;
  assign mac_clk_en_o      = st_reg.mac_en;
  assign mac_rxpm_clk_en_o = st_reg.rxpm_en;
  assign bus_clk_en_o      = st_reg.bus_en;
  assign int_clk_en_o      = st_reg.ic_en;
  assign phy_clk_en_o      = st_reg.phy_en; // [R6] [R11]
  assign phy_powered_o     = st_reg.phy_pwr;
  assign phy_reset_o       = st_reg.phy_rst;
  assign wake_pin_o        = pin_if.pin;
  assign wake_int_o        = st_reg.wint;

  // Register port and readiness checks
  AST_SLEEP_NOT_READY: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (st_reg.pst == PSWC_S_D1 || st_reg.pst == PSWC_S_D2) |-> !st_reg.ready)
    else $error("ready set while asleep");
  AST_SLEEP_READS_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
    (rd_i && !st_reg.ready && addr_i != PSWC_ADDR_PMCTRL) |=> rdata_o == 16'h0)
    else $error("register other than control readable while not ready");
  AST_WAKE_TO_D0: assert property (@(posedge clk_i) disable iff (rst_i) // [R5]
    (st_reg.pst != PSWC_S_D0 && st_reg.pst != PSWC_S_WAKE && wr_i && addr_i == PSWC_ADDR_TEST)
    |=> ##[1:66] (st_reg.pst == PSWC_S_D0 && st_reg.ready))
    else $error("no return to ready after wake write");
  AST_D0_READY: assert property (@(posedge clk_i) disable iff (rst_i) // [R20]
    st_reg.pst == PSWC_S_D0 |-> st_reg.ready) else $error("not ready in normal state");
  // A dropped write must leave every host-written enable and powerdown field alone, not only one of them
  AST_NO_WRITE_BEFORE_READ: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
    (!st_reg.read_seen && wr_i && addr_i != PSWC_ADDR_TEST) |=>
    $stable({st_reg.pin_en, st_reg.psel, st_reg.wf_en, st_reg.energy_detect_enable, st_reg.gpd, st_reg.edpd}))
    else $error("write taken before first read");

  // Wake detection and interrupt checks
  AST_D1_STATUS: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
    frame_hit |=> st_reg.wst == PSWC_WST_FRAME) else $error("frame wake status wrong");
  AST_D2_STATUS: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
    edet_hit |=> st_reg.wst == PSWC_WST_EDET) else $error("energy wake status wrong");
  AST_INT_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
    src_active |=> st_reg.wint) else $error("wake interrupt not set");
  AST_INT_HELD: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
    (wr_i && addr_i == PSWC_ADDR_INTSTS && src_active) |=> st_reg.wint)
    else $error("wake interrupt cleared while source active");
  AST_PIN_NEEDS_EN: assert property (@(posedge clk_i) disable iff (rst_i) // [R8]
    $rose(wake_pin_o) |-> $past(st_reg.pin_en)) else $error("pin raised without enable");

  // Clock gate checks
  AST_D2_GATES: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
    st_reg.pst == PSWC_S_D2 |-> !mac_clk_en_o && !bus_clk_en_o && !int_clk_en_o)
    else $error("clock left on in D2");
  AST_D1_GATES: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
    st_reg.pst == PSWC_S_D1 |-> mac_rxpm_clk_en_o && !bus_clk_en_o)
    else $error("D1 clock gating wrong");

  // PHY power-down checks
  AST_GPD_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    st_reg.gpd |-> !phy_powered_o) else $error("PHY powered in general powerdown");
  AST_PHY_RST_START: assert property (@(posedge clk_i) disable iff (rst_i) // [R17]
    (wr_ok && addr_i == PSWC_ADDR_PHYCTL && st_reg.gpd && !wdata_i[PSWC_GPD_BIT]) |=> phy_reset_o)
    else $error("no PHY reset on powerdown release");
  AST_EDPD_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (st_reg.edpd && !st_reg.energy_d) |-> !phy_powered_o) else $error("PHY powered with no line energy");
  AST_EON_SET: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
    (st_reg.edpd && line_energy_present_i && !st_reg.energy_d) |=> st_reg.eon_flag)
    else $error("energy-on flag not set");
endmodule : pswc_ctrl

// file: src/pswc_pkg.sv
package pswc_pkg;
  // Register addresses (word index on the plain port)
  localparam logic [7:0] PSWC_ADDR_PMCTRL   = 8'h00; // Power management control
  localparam logic [7:0] PSWC_ADDR_TEST     = 8'h01; // Test register, write wakes
  localparam logic [7:0] PSWC_ADDR_INTSTS   = 8'h02; // Interrupt status register
  localparam logic [7:0] PSWC_ADDR_PHYCTL   = 8'h03; // PHY power-down control bits
  localparam logic [7:0] PSWC_ADDR_PHYINT   = 8'h04; // PHY interrupt source flags
  // Control register field positions
  localparam int PSWC_RDY_BIT   = 0;  // Ready flag
  localparam int PSWC_PINEN_BIT = 1;  // Wake pin enable
  localparam int PSWC_PSEL_BIT  = 3;  // Wake pin pulse select
  localparam int PSWC_WST_LSB   = 4;  // Wake status field [5:4]
  localparam int PSWC_WFEN_BIT  = 9;  // Wake frame enable
  localparam int PSWC_EDEN_BIT  = 8;  // Energy detect enable
  localparam int PSWC_PST_LSB   = 12; // Power state field [13:12]
  // Interrupt status and PHY bits
  localparam int PSWC_WINT_BIT  = 0;  // Wake interrupt status
  localparam int PSWC_GPD_BIT   = 0;  // General power-down (phy 0.11)
  localparam int PSWC_EDPD_BIT  = 1;  // Energy detect power-down (phy 17.13)
  localparam int PSWC_EON_BIT   = 1;  // Energy-on flag (phy INT7.1)
  // Encodings
  localparam logic [1:0] PSWC_PST_D0 = 2'h0;
  localparam logic [1:0] PSWC_PST_D1 = 2'h1;
  localparam logic [1:0] PSWC_PST_D2 = 2'h2;
  localparam logic [1:0] PSWC_WST_NONE  = 2'h0;
  localparam logic [1:0] PSWC_WST_EDET  = 2'h1;
  localparam logic [1:0] PSWC_WST_FRAME = 2'h2;
  // Timing
  localparam int PSWC_CLK_KHZ     = 40000;
  localparam int PSWC_PULSE_MS    = 50;
  localparam int PSWC_PULSE_CYC   = PSWC_PULSE_MS * PSWC_CLK_KHZ;
  localparam int PSWC_WAKE_MS     = 2;
  localparam int PSWC_WAKE_MAXCYC = PSWC_WAKE_MS * PSWC_CLK_KHZ;
  localparam int PSWC_WAKE_DLY    = 64; // Clock restart settle, well below 2 ms
  localparam int PSWC_PHYRST_CYC  = 16; // Automatic PHY reset length
  // Power states, Gray in the order D0, D1, D2, waking
  typedef enum logic [1:0] {
    PSWC_S_D0   = 2'b00,
    PSWC_S_D1   = 2'b01,
    PSWC_S_D2   = 2'b11,
    PSWC_S_WAKE = 2'b10
  } pswc_state_t;
endpackage : pswc_pkg

// file: src/pswc_pin_if.sv
`timescale 1ns/10ps
// Wake-event carrier between the controller and the pin driver
interface pswc_pin_if;
  logic       event_p;   // One-cycle wake event pulse
  logic       active;    // Source still active (status and enables set)
  logic       pulse_sel; // Pulsed mode
  logic       pin;       // Registered pin level
  modport ctl (output event_p, output active, output pulse_sel, input pin);
  modport drv (input event_p, input active, input pulse_sel, output pin);
endinterface : pswc_pin_if

// file: src/pswc_pin_drv.sv
`timescale 1ns/10ps
// Wake output driver: pulsed or static
module pswc_pin_drv
  import pswc_pkg::*;
#(
  parameter int PULSE_CYC = PSWC_PULSE_CYC
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Controller side
  pswc_pin_if.drv   p
);
  typedef struct packed {
    logic        pin;
    logic [31:0] cnt;
  } pswc_drv_t;
  pswc_drv_t st_reg;
  pswc_drv_t st_next;

  // Next state: event starts, deactivation always wins
  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt != 32'h0) begin
      st_next.cnt = st_reg.cnt - 32'h1;
      if (st_reg.cnt == 32'h1) begin
        st_next.pin = 1'b0; // Pulse length over [R15]
      end
    end
    if (p.event_p) begin
      st_next.pin = 1'b1;
      st_next.cnt = p.pulse_sel ? 32'(PULSE_CYC) : 32'h0; // [R15]
    end
    if (!p.active) begin
      st_next.pin = 1'b0; // Status or enable cleared [R16]
      st_next.cnt = 32'h0;
    end
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign p.pin = st_reg.pin;

  AST_PIN_OFF: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
    !p.active |=> !p.pin) else $error("wake pin stays on without source");
endmodule : pswc_pin_drv

// file: testbench/pswc_host_model.sv
`timescale 1ns/10ps
// Host processor on the register port: one strobe per access, changed just after the edge
module pswc_host_model (
  // Clock
  input  wire logic        clk_i,
  // Register port
  output logic      [7:0]  addr_o,
  output logic      [15:0] wdata_o,
  output logic             wr_o,
  output logic             rd_o,
  input  wire logic [15:0] rdata_i
);
  // Idle bus at time zero
  initial begin
    addr_o  = 8'hff;
    wdata_o = 16'hffff;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
  end

  // One write cycle; callers only target the test register while asleep
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    // Released lines show the inverse, so a stale value never looks valid
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask : wr_reg

  // One read cycle; data is taken at the edge after the strobe was accepted
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
  endtask : rd_reg
endmodule : pswc_host_model

// file: testbench/test_power_state_wake_control.sv
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module test_power_state_wake_control;
  import pswc_pkg::*;
  localparam int PULSE = 20;  // Short pin pulse keeps the run brief
  // Design ports
  logic        clk_i;
  logic        rst_i;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        wr_stb;
  logic        rd;
  logic [15:0] rdata;
  logic        frame_det;
  logic        energy;
  logic        mac_en;
  logic        rxpm_en;
  logic        bus_en;
  logic        int_en;
  logic        phy_en;
  logic        phy_pwr;
  logic        phy_rst;
  logic        pin;
  logic        wint;
  // Bench bookkeeping
  int          error_cnt;
  int          total_checks;
  int          n;
  logic [3:0]  en;

  pswc_host_model pswc_host_model_inst (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr_stb), .rd_o(rd),
    .rdata_i(rdata));

  pswc_ctrl #(.PULSE_CYC(PULSE)) pswc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr_stb), .rd_i(rd), .rdata_o(rdata), .frame_det_i(frame_det), .line_energy_present_i(energy),
    .mac_clk_en_o(mac_en), .mac_rxpm_clk_en_o(rxpm_en), .bus_clk_en_o(bus_en), .int_clk_en_o(int_en),
    .phy_clk_en_o(phy_en), .phy_powered_o(phy_pwr), .phy_reset_o(phy_rst), .wake_pin_o(pin), .wake_int_o(wint));

  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Expected control word from its fields; en is {frame, energy, pulse select, pin}
  function automatic logic [15:0] ctrl(input logic [1:0] ps, input logic [1:0] ws, input logic rdy,
                                       input logic [3:0] e);
    logic [15:0] w;
    w = 16'h0000;
    w[PSWC_PST_LSB +: 2] = ps;
    w[PSWC_WST_LSB +: 2] = ws;
    w[PSWC_RDY_BIT]      = rdy;
    w[PSWC_PINEN_BIT]    = e[0];
    w[PSWC_PSEL_BIT]     = e[1];
    w[PSWC_EDEN_BIT]     = e[2];
    w[PSWC_WFEN_BIT]     = e[3];
    return w;
  endfunction : ctrl

  // Short forms of the host accesses
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    pswc_host_model_inst.wr_reg(a, d);
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] v;
    pswc_host_model_inst.rd_reg(a, v);
    `CHK(nm, exp, v)
  endtask : rdchk
  // Let a few edges land, then look away from the edge
  task automatic settle(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask : settle
  // Single wake pulse from the frame detector
  task automatic frame_pulse();
    repeat ($urandom_range(12, 3)) @(posedge clk_i);
    frame_det <= 1'b1;
    @(posedge clk_i);
    frame_det <= 1'b0;
    settle(3);
  endtask : frame_pulse
  // Wake write, then poll ready; the poll is also the read that re-enables writes
  task automatic wake_up();
    logic [15:0] v;
    int          k;
    wr(PSWC_ADDR_TEST, 16'($urandom));
    k = 0;
    v = 16'h0000;
    while (v[PSWC_RDY_BIT] !== 1'b1 && k < 100) begin
      pswc_host_model_inst.rd_reg(PSWC_ADDR_PMCTRL, v);
      k++;
    end
    `CHK("ready_back", 1'b1, v[PSWC_RDY_BIT])
  endtask : wake_up

  // Verdict and end of run
  task automatic results();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Watchdog, far beyond the few hundred cycles the tests take
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    results();
  end

  // Main sequence
  initial begin
    error_cnt    = 0;
    total_checks = 0;
    rst_i        = 1'b1;
    frame_det    = 1'b0;
    energy       = 1'b0;
    void'($urandom(32'hd32423a3));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Write before any read must be dropped
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b0, 4'b0001));
    rdchk("ctrl_rst", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b1, 4'b0000));
    `CHK("gates_d0", 5'b11111, {mac_en, rxpm_en, bus_en, int_en, phy_en})
    // Random enables written and read back while awake
    for (int i = 0; i < 6; i++) begin
      en = 4'($urandom);
      wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b0, en));
      rdchk("ctrl_rw", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b1, en));
    end
    // D1 with frame and pin enables, static pin
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D1, PSWC_WST_NONE, 1'b0, 4'b1001));
    settle(2);
    `CHK("gates_d1", 5'b01011, {mac_en, rxpm_en, bus_en, int_en, phy_en})
    rdchk("ctrl_d1", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D1, PSWC_WST_NONE, 1'b0, 4'b1001));
    rdchk("other_d1", PSWC_ADDR_INTSTS, 16'h0000);
    frame_pulse();
    `CHK("pin_d1", 1'b1, pin)
    `CHK("int_d1", 1'b1, wint)
    settle(PULSE + 10);
    `CHK("pin_static", 1'b1, pin)
    rdchk("ws_frame", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D1, PSWC_WST_FRAME, 1'b0, 4'b1001));
    wake_up();
    rdchk("ctrl_woke", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_FRAME, 1'b1, 4'b1001));
    wr(PSWC_ADDR_INTSTS, 16'h0001);
    settle(2);
    `CHK("int_held", 1'b1, wint)
    rdchk("int_rd", PSWC_ADDR_INTSTS, 16'h0001);
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b0, 4'b0001));
    settle(2);
    `CHK("pin_drop", 1'b0, pin)
    wr(PSWC_ADDR_INTSTS, 16'h0001);
    settle(2);
    `CHK("int_clr", 1'b0, wint)
    // D1 without pin enable: interrupt only
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D1, PSWC_WST_NONE, 1'b0, 4'b1000));
    frame_pulse();
    `CHK("pin_off", 1'b0, pin)
    `CHK("int_nopin", 1'b1, wint)
    wake_up();
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b0, 4'b0000));
    wr(PSWC_ADDR_INTSTS, 16'h0001);
    settle(2);
    `CHK("int_clr2", 1'b0, wint)
    // Energy power-down first, then D2 with carrier already present
    wr(PSWC_ADDR_PHYCTL, 16'h0002);
    settle(2);
    `CHK("phy_edpd_off", 1'b0, phy_pwr)
    @(posedge clk_i);
    energy <= 1'b1;
    settle(3);
    rdchk("eon_set", PSWC_ADDR_PHYINT, 16'h0002);
    rdchk("eon_clr", PSWC_ADDR_PHYINT, 16'h0000);
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D2, PSWC_WST_NONE, 1'b0, 4'b0111));
    settle(2);
    `CHK("gates_d2", 3'b000, {mac_en, bus_en, int_en})
    `CHK("pin_d2", 1'b1, pin)
    settle(PULSE + 5);
    `CHK("pin_pulse_end", 1'b0, pin)
    rdchk("ws_edet", PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D2, PSWC_WST_EDET, 1'b0, 4'b0111));
    wake_up();
    wr(PSWC_ADDR_PHYCTL, 16'h0000);
    wr(PSWC_ADDR_PMCTRL, ctrl(PSWC_PST_D0, PSWC_WST_NONE, 1'b0, 4'b0000));
    wr(PSWC_ADDR_INTSTS, 16'h0001);
    settle(2);
    `CHK("int_clr3", 1'b0, wint)
    `CHK("gates_back", 5'b11111, {mac_en, rxpm_en, bus_en, int_en, phy_en})
    // General power-down and automatic reset on release
    wr(PSWC_ADDR_PHYCTL, 16'h0001);
    settle(2);
    `CHK("phy_down", 1'b0, phy_pwr)
    rdchk("phyctl_rd", PSWC_ADDR_PHYCTL, 16'h0001);
    wr(PSWC_ADDR_PHYCTL, 16'h0000);
    n = 0;
    // The reset starts at the edge that takes the write, so count from just after it
    #1;
    repeat (40) begin
      if (phy_rst === 1'b1) n++;
      settle(1);
    end
    `CHK("phy_rst_len", PSWC_PHYRST_CYC, n)
    `CHK("phy_up", 1'b1, phy_pwr)
    results();
  end
endmodule : test_power_state_wake_control
